// ---- src/cpom_pkg.sv ----
// cpom_pkg: option encodings, image words, timing and pin grouping types
// for the configuration port option mux; shared by the mux, its checker and the testbench.
package cpom_pkg;

  // status pin option settings
  typedef enum logic [2:0] {
    CPOM_SDM_DISABLE,
    CPOM_SDM_REQUEST,
    CPOM_SDM_COMPLETE,
    CPOM_SDM_STARTUP,
    CPOM_SDM_REQ_COMPLETE,
    CPOM_SDM_ALL
  } cpom_sdm_t;

  // master spi option settings
  typedef enum logic [1:0] {
    CPOM_MSPI_DISABLE,
    CPOM_MSPI_ENABLE,
    CPOM_MSPI_USER_ONLY
  } cpom_mspi_t;

  // persisted option word
  typedef struct packed {
    logic jtag_keep;
    logic sspi_keep;
    cpom_mspi_t mspi_mode;
    logic i2c_keep;
    cpom_sdm_t status_pin_option;
    logic image_external;
    logic field_reload_enable;
  } cpom_opts_t;

  // resulting pin ownership
  typedef struct packed {
    logic jtag_to_cfg;
    logic spi_to_cfg;
    logic spi_to_efb;
    logic spi_gpio;
    logic i2c_to_cfg;
    logic i2c_ctrl_en;
    logic req_kept;
    logic done_kept;
    logic init_kept;
  } cpom_own_t;

  // image stream constants
  localparam logic [15:0] CPOM_SOD_WORD = 16'hBDB3;
  localparam int CPOM_CTRL_BITS = 32;
  localparam int CPOM_RATE_LSB = 0;
  localparam int CPOM_RATE_W = 8;

  // timing
  localparam int CPOM_CLK_HZ = 20000000;
  localparam int CPOM_START_KHZ = 2080;
  localparam int CPOM_MAX_KHZ = 133000;
  localparam int CPOM_TOL_PERMILLE = 55;
  localparam int CPOM_START_DIV =
    (CPOM_CLK_HZ / 1000 + 2 * CPOM_START_KHZ - 1) / (2 * CPOM_START_KHZ);
  localparam int CPOM_SWITCH_DLY = 4;
  localparam int CPOM_DIV_W = 8;

endpackage : cpom_pkg

// ---- src/cpom_clk_div.sv ----
// cpom_clk_div: divides clk into the master configuration clock level,
// with a half period that may change on the fly, applied to the count in progress.
// assumes a single clk domain; half period count comes from same domain.
`timescale 1ns/1ns
`default_nettype none
module cpom_clk_div #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [DIV_W-1:0] half_period,
  // output
  output logic mclk,
  output logic rise
);
  logic [DIV_W-1:0] cnt;

  // count half periods and toggle the clock level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
      mclk <= 1'b0;
      rise <= 1'b0;
    end else if (!run) begin
      cnt <= '0;
      mclk <= 1'b0;
      rise <= 1'b0;
    end else if (cnt + 1'b1 >= half_period) begin
      cnt <= '0;
      mclk <= ~mclk;
      rise <= ~mclk;
    end else begin
      cnt <= cnt + 1'b1;
      rise <= 1'b0;
    end
  end
endmodule : cpom_clk_div
`default_nettype wire

// ---- src/cpom_mux.sv ----
// cpom_mux: configuration port option mux. decides pin ownership in user
// mode from persisted options and runs the master clock from flash.
// assumes options are stable nonvolatile levels; pins are asynchronous.
//
// Overview of operation
// - jtag keep set: four jtag pins form the test access port
// - jtag keep clear: select pin high gives jtag, low gives gpio
// - select pin only has meaning while jtag keep is clear
// - slave spi keep: spi pins stay attached to configuration logic
// - spi pins are gpio only when slave and master spi disabled
// - master spi with external image boots flash, internal gives dual boot
// - master spi enable or user-only keeps pins, embedded block spi owns
// - i2c needs option enabled and bus clock at least 7.5x bit rate
// - i2c option clear: i2c pins become gpio
// - embedded i2c controllers run only with i2c option enabled
// - status option disabled: all three status pins become gpio
// - kept request pin low in user mode starts reconfiguration
// - complete-only setting frees request and startup pins
// - startup setting frees request and complete pins
// - request+complete frees startup; all-pins setting keeps all three
// - without request pin, reload only via reload command on live port
// - master clock starts near 2.08 mhz, within 5.5 percent
// - image read as padding, start word, then control register
// - shortly after rate field capture clock switches, up to 133 mhz; here at most 10 mhz (one clk per half period at 20 mhz)
// - options persist in storage; clock rate comes from the image
`timescale 1ns/1ns
`default_nettype none
module cpom_mux
  import cpom_pkg::*;
#(
  parameter int DIV_W = CPOM_DIV_W,
  parameter int RATE_W = CPOM_RATE_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // persisted options and mode
  input wire cpom_pkg::cpom_opts_t opts,
  input wire logic cfg_sample,
  input wire logic user_mode,
  input wire logic boot_start,
  // pins from outside
  input wire logic jtag_pin_select,
  input wire logic reconfigure_request_pin,
  input wire logic spi_miso,
  // embedded block bus clock check and reload command
  input wire logic bus_clk_ok,
  input wire logic reload_cmd,
  // ownership and boot outputs
  output cpom_pkg::cpom_own_t own,
  output logic boot_flash,
  output logic boot_dual,
  output logic reconfig_start,
  output logic mclk_out,
  output logic mclk_oe,
  output logic [RATE_W-1:0] master_cfg_clock_rate,
  output logic rate_switched
);
  import cpom_pkg::*;

  typedef enum {
    CPOM_ST_IDLE,
    CPOM_ST_SOD,
    CPOM_ST_CTRL,
    CPOM_ST_WAIT,
    CPOM_ST_RUN
  } cpom_state_t;

  cpom_opts_t held;
  cpom_state_t state;
  logic sel_s1, sel_s2, req_s1, req_s2, req_d, miso_s1, miso_s2;
  logic [15:0] sod_sr;
  logic [CPOM_CTRL_BITS-1:0] ctrl_sr;
  logic [5:0] bit_cnt;
  logic [2:0] wait_cnt;
  logic [DIV_W-1:0] half_period;
  logic mclk, mrise, spi_live, cfg_port_live;

  // sample options at configuration time and hold them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      held <= '0;
    end else if (cfg_sample && !user_mode) begin
      held <= opts;
    end
  end

  // two-flop synchronisers for pin inputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      req_s1 <= 1'b1;
      req_s2 <= 1'b1;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      sel_s1 <= jtag_pin_select;
      sel_s2 <= sel_s1;
      req_s1 <= reconfigure_request_pin;
      req_s2 <= req_s1;
      miso_s1 <= spi_miso;
      miso_s2 <= miso_s1;
    end
  end

  assign spi_live = held.sspi_keep;
  assign cfg_port_live = held.jtag_keep || sel_s2 || spi_live ||
    (held.i2c_keep && bus_clk_ok);

  // pin ownership from the held options
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      own <= '0;
    end else if (!user_mode) begin
      own <= '0;
    end else begin
      // select pin honoured only when keep is clear
      own.jtag_to_cfg <= held.jtag_keep ? 1'b1 : sel_s2;
      own.spi_to_cfg <= held.sspi_keep;
      own.spi_to_efb <= held.mspi_mode != CPOM_MSPI_DISABLE;
      own.spi_gpio <= !held.sspi_keep &&
        held.mspi_mode == CPOM_MSPI_DISABLE;
      own.i2c_to_cfg <= held.i2c_keep && bus_clk_ok;
      own.i2c_ctrl_en <= held.i2c_keep;
      unique case (held.status_pin_option)
        CPOM_SDM_REQUEST: begin
          own.req_kept <= 1'b1;
          own.done_kept <= 1'b0;
          own.init_kept <= 1'b0;
        end
        CPOM_SDM_COMPLETE: begin
          own.req_kept <= 1'b0;
          own.done_kept <= 1'b1;
          own.init_kept <= 1'b0;
        end
        CPOM_SDM_STARTUP: begin
          own.req_kept <= 1'b0;
          own.done_kept <= 1'b0;
          own.init_kept <= 1'b1;
        end
        CPOM_SDM_REQ_COMPLETE: begin
          own.req_kept <= 1'b1;
          own.done_kept <= 1'b1;
          own.init_kept <= 1'b0;
        end
        CPOM_SDM_ALL: begin
          own.req_kept <= 1'b1;
          own.done_kept <= 1'b1;
          own.init_kept <= 1'b1;
        end
        default: begin
          own.req_kept <= 1'b0;
          own.done_kept <= 1'b0;
          own.init_kept <= 1'b0;
        end
      endcase
    end
  end

  // reconfiguration triggers: falling request pin or reload command
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_d <= 1'b1;
      reconfig_start <= 1'b0;
    end else begin
      req_d <= req_s2;
      reconfig_start <= user_mode && (
        (own.req_kept && req_d && !req_s2) ||
        (reload_cmd && cfg_port_live));
    end
  end

  // boot mode from master spi option and image storage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_flash <= 1'b0;
      boot_dual <= 1'b0;
    end else begin
      boot_flash <= held.mspi_mode == CPOM_MSPI_ENABLE &&
        held.image_external;
      boot_dual <= held.mspi_mode == CPOM_MSPI_ENABLE &&
        !held.image_external;
    end
  end

  // master clock divider; start rate until the image sets another
  cpom_clk_div #(
    .DIV_W(DIV_W)
  ) u_div (
    .clk(clk),
    .rst_b(rst_b),
    .run(state != CPOM_ST_IDLE),
    .half_period(half_period),
    .mclk(mclk),
    .rise(mrise)
  );

  // image reader: padding, start word, control register, switch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= CPOM_ST_IDLE;
      sod_sr <= '0;
      ctrl_sr <= '0;
      bit_cnt <= '0;
      wait_cnt <= '0;
    end else begin
      unique case (state)
        CPOM_ST_IDLE: begin
          sod_sr <= '0;
          if (boot_start && (boot_flash || boot_dual)) begin
            state <= CPOM_ST_SOD;
          end
        end
        CPOM_ST_SOD: begin
          if (mrise) begin
            sod_sr <= {sod_sr[14:0], miso_s2};
            if ({sod_sr[14:0], miso_s2} == CPOM_SOD_WORD) begin
              state <= CPOM_ST_CTRL;
              bit_cnt <= '0;
            end
          end
        end
        CPOM_ST_CTRL: begin
          if (mrise) begin
            ctrl_sr <= {ctrl_sr[CPOM_CTRL_BITS-2:0], miso_s2};
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == 6'(CPOM_CTRL_BITS - 1)) begin
              state <= CPOM_ST_WAIT;
              wait_cnt <= '0;
            end
          end
        end
        CPOM_ST_WAIT: begin
          wait_cnt <= wait_cnt + 3'h1;
          if (wait_cnt == 3'(CPOM_SWITCH_DLY - 1)) begin
            state <= CPOM_ST_RUN;
          end
        end
        CPOM_ST_RUN: begin
          if (!boot_start) begin
            state <= CPOM_ST_IDLE;
          end
        end
      endcase
    end
  end

  // half period: start value, then from captured rate field
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      half_period <= DIV_W'(CPOM_START_DIV);
      master_cfg_clock_rate <= '0;
      rate_switched <= 1'b0;
    end else if (state == CPOM_ST_IDLE) begin
      half_period <= DIV_W'(CPOM_START_DIV);
      rate_switched <= 1'b0;
    end else if (state == CPOM_ST_WAIT &&
                 wait_cnt == 3'(CPOM_SWITCH_DLY - 1)) begin
      master_cfg_clock_rate <= ctrl_sr[CPOM_RATE_LSB +: RATE_W];
      // zero keeps start rate; fastest is one clk per half period
      if (ctrl_sr[CPOM_RATE_LSB +: RATE_W] != '0) begin
        half_period <= DIV_W'(ctrl_sr[CPOM_RATE_LSB +: RATE_W]);
      end
      rate_switched <= 1'b1;
    end
  end

  // registered clock pin outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mclk_out <= 1'b0;
      mclk_oe <= 1'b0;
    end else begin
      mclk_out <= mclk;
      mclk_oe <= state != CPOM_ST_IDLE;
    end
  end
endmodule : cpom_mux
`default_nettype wire

// ---- verif/cpom_mux_properties.sv ----
// cpom_mux_chk: port assertions for the configuration port option mux.
// assumes one clk domain; bound to cpom_mux at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module cpom_mux_chk
  import cpom_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // watched inputs
  input wire cpom_pkg::cpom_opts_t opts,
  input wire logic cfg_sample,
  input wire logic user_mode,
  input wire logic boot_start,
  input wire logic reconfigure_request_pin,
  input wire logic reload_cmd,
  // watched outputs
  input wire cpom_pkg::cpom_own_t own,
  input wire logic boot_flash,
  input wire logic boot_dual,
  input wire logic reconfig_start,
  input wire logic mclk_oe,
  input wire logic rate_switched
);
  cpom_opts_t sh;
  logic [1:0] cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // shadow of the latched options
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sh <= '0;
    else if (cfg_sample && !user_mode) sh <= opts;
  end
  // settled user mode cycles, saturating
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt <= 2'h0;
    else if (!user_mode) cnt <= 2'h0;
    else if (cnt != 2'h3) cnt <= cnt + 2'h1;
  end
  // expected status pins: request, complete, startup
  function automatic logic [2:0] sdm_pins(input cpom_sdm_t s);
    case (s)
      CPOM_SDM_REQUEST: return 3'h4;
      CPOM_SDM_COMPLETE: return 3'h2;
      CPOM_SDM_STARTUP: return 3'h1;
      CPOM_SDM_REQ_COMPLETE: return 3'h6;
      CPOM_SDM_ALL: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction
  jtag_kept_a: assert property (
    cnt == 2'h3 && sh.jtag_keep |-> own.jtag_to_cfg)
    else $error("jtag port dropped");
  spi_gpio_a: assert property (cnt == 2'h3 |->
    own.spi_gpio == (!sh.sspi_keep && sh.mspi_mode == CPOM_MSPI_DISABLE))
    else $error("spi gpio");
  i2c_off_a: assert property (
    cnt == 2'h3 && !sh.i2c_keep |-> !own.i2c_to_cfg)
    else $error("i2c attached while off");
  status_pins_a: assert property (cnt == 2'h3 |->
    {own.req_kept, own.done_kept, own.init_kept} ==
    sdm_pins(sh.status_pin_option))
    else $error("status pins wrong");
  own_idle_a: assert property (!user_mode [*3] |-> own == '0)
    else $error("ownership outside user mode");
  pulse_one_a: assert property (reconfig_start |=> !reconfig_start)
    else $error("reconfig pulse too long");
  req_start_a: assert property (
    $fell(reconfigure_request_pin) && user_mode && own.req_kept
    |-> ##[3:5] reconfig_start) else $error("no reconfig");
  reload_go_a: assert property (
    reload_cmd && user_mode && own.jtag_to_cfg
    |-> ##[1:2] reconfig_start) else $error("reload ignored");
  boot_mode_a: assert property ($stable(sh) [*3] |-> boot_flash ==
    (sh.mspi_mode == CPOM_MSPI_ENABLE && sh.image_external) && boot_dual ==
    (sh.mspi_mode == CPOM_MSPI_ENABLE && !sh.image_external))
    else $error("boot");
  mclk_on_a: assert property (
    $rose(boot_start) && (boot_flash || boot_dual)
    |-> ##[1:3] mclk_oe) else $error("master clock not enabled");
  cover property (reconfig_start);
  cover property ($rose(rate_switched));
  cover property (own.spi_gpio && user_mode);
endmodule : cpom_mux_chk
bind cpom_mux cpom_mux_chk i_chk (.clk, .rst_b, .opts, .cfg_sample, .user_mode,
  .boot_start, .reconfigure_request_pin, .reload_cmd, .own, .boot_flash,
  .boot_dual, .reconfig_start, .mclk_oe, .rate_switched);
`default_nettype wire

// ---- verif/cpom_flash_model.sv ----
// cpom_flash_model: serial flash stand-in; shifts padding, start word and
// control word msb first, new data on each master clock fall.
// assumes the mux samples on master clock rises while it enables the clock.
`timescale 1ns/1ns
`default_nettype none
module cpom_flash_model #(
  parameter logic [31:0] CTRL = 32'h0000_0003
) (
  // master clock and select
  input wire logic mclk,
  input wire logic oe,
  // data to the mux
  output logic miso
);
  logic [55:0] sr;
  // load stream on select, first bit ready before first rise
  initial miso = 1'b0;
  always @(posedge oe) begin
    sr = {8'hFF, 16'hBDB3, CTRL};
    miso = sr[55];
  end
  // next bit on each fall while oe is high; load and release also drive the line
  always @(negedge mclk) if (oe) begin
    sr = sr << 1;
    miso = sr[55];
  end
  // released line shows the inverse of its last level
  always @(negedge oe) miso = ~miso;
endmodule : cpom_flash_model
`default_nettype wire

// ---- verif/tb.sv ----
// tb: drives options, pins and boot; checks ownership, reconfiguration
// and master clock rates. the flash model answers on the master clock.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cpom_pkg::*;
  localparam logic [7:0] RATE = 8'h03;
  logic clk = 0, rst_b = 0, cfg_sample = 0, user_mode = 0, boot_start = 0;
  logic jsel = 0, req_pin = 1, bus_ok = 0, reload = 0, miso, seen;
  logic rstart, mclk, moe, rsw, boot_flash, boot_dual;
  logic [7:0] rate, n;
  cpom_opts_t opts = '0, o;
  cpom_own_t own, e;
  int mismatches = 0, checks_done = 0;
  // clock
  always #25 clk = ~clk;
  cpom_mux i_dut (.clk(clk), .rst_b(rst_b), .opts(opts),
    .cfg_sample(cfg_sample), .user_mode(user_mode), .boot_start(boot_start),
    .jtag_pin_select(jsel), .reconfigure_request_pin(req_pin),
    .spi_miso(miso), .bus_clk_ok(bus_ok), .reload_cmd(reload), .own(own),
    .boot_flash(boot_flash), .boot_dual(boot_dual), .reconfig_start(rstart),
    .mclk_out(mclk), .mclk_oe(moe), .master_cfg_clock_rate(rate),
    .rate_switched(rsw));
  cpom_flash_model #(.CTRL({24'h0, RATE})) i_flash (.mclk(mclk), .oe(moe),
    .miso(miso));
  task automatic cmp_own(input cpom_own_t got, exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t own got %h exp %h", $time, got, exp);
    end
  endtask : cmp_own
  task automatic cmp_val(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t value got %h exp %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // latch options outside user mode, then enter user mode and settle
  task automatic setup(input cpom_opts_t v, input logic js, ok);
    @(posedge clk) begin
      opts <= v;
      jsel <= js;
      bus_ok <= ok;
      cfg_sample <= 1;
      user_mode <= 0;
    end
    @(posedge clk) cfg_sample <= 0;
    @(posedge clk) user_mode <= 1;
    repeat (6) @(posedge clk);
    #1;
  endtask : setup
  // pull request pin low (cmd 0) or pulse reload (cmd 1), look for start
  task automatic watch(input logic cmd, output logic hit);
    hit = 0;
    @(posedge clk) begin
      req_pin <= cmd;
      reload <= cmd;
    end
    @(posedge clk) reload <= 0;
    repeat (8) begin
      #1 hit = hit | rstart;
      @(posedge clk);
    end
    req_pin <= 1;
  endtask : watch
  // clk cycles in one master clock half period
  task automatic halfp(output logic [7:0] cnt);
    logic m;
    cnt = 0;
    #1 m = mclk;
    while (mclk === m) @(posedge clk) #1;
    m = mclk;
    while (mclk === m) begin
      @(posedge clk) #1;
      cnt++;
    end
  endtask : halfp
  function automatic cpom_own_t exp_own(input cpom_opts_t v, input logic js,
    input logic ok);
    cpom_own_t x;
    cpom_sdm_t s;
    s = v.status_pin_option;
    x.jtag_to_cfg = v.jtag_keep | js;
    x.spi_to_cfg = v.sspi_keep;
    x.spi_to_efb = v.mspi_mode != CPOM_MSPI_DISABLE;
    x.spi_gpio = !v.sspi_keep && v.mspi_mode == CPOM_MSPI_DISABLE;
    x.i2c_to_cfg = v.i2c_keep & ok;
    x.i2c_ctrl_en = v.i2c_keep;
    x.req_kept = s inside {CPOM_SDM_REQUEST, CPOM_SDM_REQ_COMPLETE,
      CPOM_SDM_ALL};
    x.done_kept = s inside {CPOM_SDM_COMPLETE, CPOM_SDM_REQ_COMPLETE,
      CPOM_SDM_ALL};
    x.init_kept = s inside {CPOM_SDM_STARTUP, CPOM_SDM_ALL};
    return x;
  endfunction : exp_own
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1;
    for (int i = 0; i < 6; i++) begin
      o = '0;
      o.jtag_keep = i[0];
      o.sspi_keep = i[1];
      o.mspi_mode = cpom_mspi_t'(i % 3);
      o.i2c_keep = i[2];
      o.status_pin_option = cpom_sdm_t'(i);
      o.image_external = i[0];
      setup(o, i[1] ^ i[0], i[0]);
      e = exp_own(o, i[1] ^ i[0], i[0]);
      cmp_own(own, e);
      e.spi_gpio = o.mspi_mode == CPOM_MSPI_ENABLE;
      cmp_val(8'(boot_flash), 8'(e.spi_gpio && i[0]));
      cmp_val(8'(boot_dual), 8'(e.spi_gpio && !i[0]));
      e = exp_own(o, i[1] ^ i[0], i[0]);
      watch(0, seen);
      cmp_val(8'(seen), 8'(e.req_kept));
      watch(1, seen);
      n = 8'(e.jtag_to_cfg | e.spi_to_cfg | e.i2c_to_cfg);
      cmp_val(8'(seen), n);
    end
    $display("test ownership done");
    @(posedge clk) begin
      opts <= ~opts;
      cfg_sample <= 1;
    end
    @(posedge clk) cfg_sample <= 0;
    repeat (4) @(posedge clk);
    #1 cmp_own(own, e);
    @(posedge clk) user_mode <= 0;
    repeat (3) @(posedge clk);
    #1 cmp_own(own, '0);
    $display("test hold done");
    o = '0;
    o.mspi_mode = CPOM_MSPI_ENABLE;
    o.image_external = 1;
    o.field_reload_enable = 1;
    setup(o, 0, 0);
    @(posedge clk) begin
      user_mode <= 0;
      boot_start <= 1;
    end
    halfp(n);
    cmp_val(8'(20000 / (2 * n) inside {[1966:2194]}), 8'h01);
    for (int k = 0; k < 3000 && rsw !== 1'b1; k++) @(posedge clk);
    #1 cmp_val(rate, RATE);
    cmp_val(8'(rsw), 8'h01);
    cmp_val(8'(moe), 8'h01);
    halfp(n);
    halfp(n);
    cmp_val(n, RATE);
    $display("test boot clock done");
    end_sim;
  end
endmodule : tb
`default_nettype wire
